// File: vme_slave.sv
// Backplane A32/D32 slave with vectored interrupt and processor interrupts
`timescale 1ns/1ns
`default_nettype none
`include "vme_slave_map.svh"

module vme_slave
	import vme_slave_pkg::*;
#(
	parameter int DPR_DEPTH = 1024
) (
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire bus_req_t    bus,
	input  wire logic [2:0]  iack_level,
	input  wire logic [31:0] data_in,
	output var  logic [31:0] data_out,
	output var  logic        data_oe,
	output var  logic        dtack_n,
	output var  logic        dtack_oe,
	output var  logic [7:1]  irq_n,
	input  wire logic [7:0]  base_switch,
	input  wire dsp_req_t    dsp,
	output var  logic [7:0]  dsp_rdata,
	output var  logic        dsp_ready,
	input  wire logic        frame_start_marker,
	input  wire logic        diag_done,
	output var  logic [3:0]  dsp_irq
);

	// ------------------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------------------
	typedef enum logic [1:0] {
		st_idle,
		st_ack,
		st_wait
	} cyc_state_t;

	cyc_state_t  state;
	logic        am_single;
	logic        am_block;
	logic        sel;
	logic        strobe;
	logic        is_dpr;
	logic        is_ctl;
	logic [9:0]  dpr_idx;
	logic [2:0]  irq_level;
	logic [7:0]  irq_vector;
	logic        irq_pend;
	logic        diag_flag;
	logic        frame_q;
	logic        irq_mbox;
	logic        irq_frame;
	logic        irq_diag;
	logic        irq_spare;
	logic        host_mbox_wr;
	logic        dsp_mbox_acc;
	logic        iack_hit;
	logic [7:0]  dpr [DPR_DEPTH];
	mem_owner_t  owner;
	logic [31:0] next_rdata;

	assign am_single = bus.am == `AM_EXT_USR_DATA || bus.am == `AM_EXT_USR_PROG
		|| bus.am == `AM_EXT_SUP_DATA || bus.am == `AM_EXT_SUP_PROG;
	assign am_block = bus.am == `AM_EXT_USR_BLOCK || bus.am == `AM_EXT_SUP_BLOCK;
	// Longword: both strobes, LWORD low, A1 low (A0 is not a line)
	assign strobe = !bus.as_n && bus.ds_n == 2'b00 && !bus.lword_n && !bus.addr[1];
	assign sel = strobe && bus.iack_n && (am_single || am_block)
		&& bus.addr[31:24] == base_switch;
	assign is_dpr = bus.addr[23:16] >= `DPR_BASE_HI && bus.addr[23:16] <= `DPR_LIMIT_HI;
	assign is_ctl = bus.addr[23:16] >= `CTL_BASE_HI && bus.addr[23:16] <= `CTL_LIMIT_HI;
	assign dpr_idx = bus.addr[11:2];
	assign host_mbox_wr = sel && state == st_idle && is_dpr && !bus.write_n
		&& dpr_idx == `DPR_HOST_MBOX;
	assign dsp_mbox_acc = dsp.req && owner == mem_dsp && dsp.addr == `DPR_DSP_MBOX;
	assign iack_hit = !bus.iack_n && !bus.as_n && bus.ds_n[0] == 1'b0
		&& irq_pend && iack_level == irq_level;

	mem_arbiter u_arb (
		.clk      (clk),
		.sys_rst  (sys_rst),
		.host_req (sel && is_dpr && state == st_idle),
		.dsp_req  (dsp.req),
		.owner    (owner)
	);

	// ------------------------------------------------------------------------
	// Read mux
	// ------------------------------------------------------------------------
	always_comb begin
		next_rdata = 32'h0000_0000;
		if (!bus.iack_n) begin
			next_rdata = {24'h00_0000, irq_vector};
		end else if (is_dpr) begin
			next_rdata = {24'h00_0000, dpr[dpr_idx]};
		end else if (bus.addr[23:0] == `CTL_IRQ_LEVEL) begin
			next_rdata = {29'h0000_0000, irq_level};
		end else if (bus.addr[23:0] == `CTL_IRQ_VECTOR) begin
			next_rdata = {24'h00_0000, irq_vector};
		end else if (bus.addr[23:0] == `CTL_IRQ_STATUS) begin
			next_rdata = {30'h0000_0000, diag_flag, irq_pend};
		end else begin
			next_rdata = 32'h0000_0000;
		end
	end

	// ------------------------------------------------------------------------
	// Bus cycle sequencer
	// ------------------------------------------------------------------------
	// Clocked by the 16 MHz system clock
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state    <= st_idle;
			dtack_n  <= 1'b1;
			dtack_oe <= 1'b0;
			data_oe  <= 1'b0;
			data_out <= 32'h0000_0000;
		end else begin
			case (state)
				st_idle: begin
					if (sel || iack_hit) begin
						state    <= st_ack;
						data_out <= next_rdata;
						data_oe  <= bus.write_n;
					end else begin
						dtack_oe <= 1'b0;
						data_oe  <= 1'b0;
					end
				end
				st_ack: begin
					dtack_n  <= 1'b0;
					dtack_oe <= 1'b1;
					state    <= st_wait;
				end
				st_wait: begin
					// Release once the master drops its strobes
					if (bus.as_n || bus.ds_n != 2'b00 && bus.iack_n) begin
						dtack_n  <= 1'b1;
						dtack_oe <= 1'b0;
						data_oe  <= 1'b0;
						state    <= st_idle;
					end
				end
				default: begin
					state <= st_idle;
				end
			endcase
		end
	end

	// ------------------------------------------------------------------------
	// Dual-port memory and control writes
	// ------------------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (sel && state == st_idle && !bus.write_n && is_dpr) begin
			dpr[dpr_idx] <= data_in[7:0];
		end else if (dsp.req && dsp.we && owner == mem_dsp) begin
			dpr[dsp.addr] <= dsp.wdata;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			dsp_rdata <= 8'h00;
			dsp_ready <= 1'b0;
		end else begin
			dsp_ready <= dsp.req && owner == mem_dsp;
			dsp_rdata <= dpr[dsp.addr];
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			irq_level  <= `IRQ_LEVEL_RST;
			irq_vector <= `IRQ_VECTOR_RST;
		end else if (sel && state == st_idle && !bus.write_n && is_ctl) begin
			if (bus.addr[23:0] == `CTL_IRQ_LEVEL) begin
				irq_level <= data_in[2:0];
			end else if (bus.addr[23:0] == `CTL_IRQ_VECTOR) begin
				irq_vector <= data_in[7:0];
			end
		end
	end

	// ------------------------------------------------------------------------
	// Bus interrupt request
	// ------------------------------------------------------------------------
	// A new mailbox access wins over the acknowledge that clears it
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			irq_pend <= 1'b0;
		end else if (dsp_mbox_acc && irq_level != 3'h0) begin
			irq_pend <= 1'b1;
		end else if (iack_hit && state == st_idle) begin
			irq_pend <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			irq_n <= 7'h7f;
		end else begin
			for (int i = 1; i <= 7; i++) begin
				irq_n[i] <= !(irq_pend && irq_level == 3'(i));
			end
		end
	end

	// ------------------------------------------------------------------------
	// Processor interrupts
	// ------------------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			frame_q   <= 1'b0;
			diag_flag <= 1'b0;
		end else begin
			frame_q   <= frame_start_marker;
			diag_flag <= diag_done;
		end
	end

	edge_irq #(.PULSE_CYC(`DSP_PULSE_CYC)) u_irq_mbox (
		.clk     (clk),
		.sys_rst (sys_rst),
		.trigger (host_mbox_wr),
		.irq     (irq_mbox)
	);

	edge_irq #(.PULSE_CYC(`DSP_PULSE_CYC)) u_irq_frame (
		.clk     (clk),
		.sys_rst (sys_rst),
		.trigger (frame_q != frame_start_marker),
		.irq     (irq_frame)
	);

	edge_irq #(.PULSE_CYC(`DSP_PULSE_CYC)) u_irq_diag (
		.clk     (clk),
		.sys_rst (sys_rst),
		.trigger (diag_done && !diag_flag),
		.irq     (irq_diag)
	);

	// Third processor line has no source on this board; held low
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			irq_spare <= 1'b0;
		end else begin
			irq_spare <= 1'b0;
		end
	end

	// One driver for the whole vector; every bit is a flop output
	assign dsp_irq = {irq_diag, irq_spare, irq_frame, irq_mbox};

	// ------------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------------
	sequence access_taken;
		state == st_idle && sel;
	endsequence

	sequence ack_driven;
		!dtack_n && dtack_oe;
	endsequence

	bad_am_a: assert property (@(posedge clk) disable iff (sys_rst)
		state == st_idle && !am_single && !am_block && bus.iack_n && !iack_hit
		|=> !dtack_oe) else $error("acknowledged bad modifier");
	short_width_a: assert property (@(posedge clk) disable iff (sys_rst)
		state == st_idle && bus.lword_n && bus.iack_n
		|=> !dtack_oe && !data_oe) else $error("drove for short access");
	block_ok_a: assert property (@(posedge clk) disable iff (sys_rst)
		access_taken and am_block |-> ##2 ack_driven) else $error("block cycle not served");
	ack_timing_a: assert property (@(posedge clk) disable iff (sys_rst)
		access_taken |-> ##2 ack_driven) else $error("acknowledge late");
	base_miss_a: assert property (@(posedge clk) disable iff (sys_rst)
		state == st_idle && bus.addr[31:24] != base_switch && bus.iack_n
		|=> !dtack_oe) else $error("wrong base acknowledged");
	mbox_irq_a: assert property (@(posedge clk) disable iff (sys_rst)
		dsp_mbox_acc && irq_level != 3'h0 |=> ##1 !irq_n[irq_level])
		else $error("bus request missing");
	host_mbox_a: assert property (@(posedge clk) disable iff (sys_rst)
		host_mbox_wr |=> dsp_irq[0]) else $error("processor mailbox irq missing");
	frame_edge_a: assert property (@(posedge clk) disable iff (sys_rst)
		frame_q != frame_start_marker |=> dsp_irq[1]) else $error("frame edge lost");
	diag_irq_a: assert property (@(posedge clk) disable iff (sys_rst)
		diag_done && !diag_flag |=> dsp_irq[3]) else $error("diag irq missing");
	irq_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
		irq_pend && !iack_hit |=> irq_pend) else $error("request dropped early");
	vector_out_a: assert property (@(posedge clk) disable iff (sys_rst)
		state == st_idle && iack_hit |=> data_out == {24'h00_0000, $past(irq_vector)})
		else $error("wrong vector");

endmodule : vme_slave

`default_nettype wire

// File: vme_slave_map.svh
// Address, modifier, timing and interrupt constants for the backplane slave
`ifndef VME_SLAVE_MAP_SVH
`define VME_SLAVE_MAP_SVH

// ----------------------------------------------------------------------------
// Address modifiers
// ----------------------------------------------------------------------------
`define AM_EXT_USR_DATA    6'h09
`define AM_EXT_USR_PROG    6'h0a
`define AM_EXT_USR_BLOCK   6'h0b
`define AM_EXT_SUP_DATA    6'h0d
`define AM_EXT_SUP_PROG    6'h0e
`define AM_EXT_SUP_BLOCK   6'h0f

// ----------------------------------------------------------------------------
// Local address map (A23..A0)
// ----------------------------------------------------------------------------
`define DPR_BASE_HI        8'hc0
`define DPR_LIMIT_HI       8'hc1
`define CTL_BASE_HI        8'hc2
`define CTL_LIMIT_HI       8'hc3
`define DPR_HOST_MBOX      10'h3fe
`define DPR_DSP_MBOX       10'h3ff
`define CTL_IRQ_LEVEL      24'hc20000
`define CTL_IRQ_VECTOR     24'hc20004
`define CTL_IRQ_STATUS     24'hc20008
`define CTL_DIAG_DONE      24'hc2000c

// ----------------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------------
`define IRQ_LEVEL_RST      3'h0
`define IRQ_VECTOR_RST     8'h00
`define SYSCLK_HZ          16000000
`define BUS_TIMEOUT_NS     16000
`define BUS_TIMEOUT_CYC    ((`BUS_TIMEOUT_NS * (`SYSCLK_HZ / 1000000)) / 1000)
`define DSP_PULSE_CYC      4

`endif

// File: vme_slave_pkg.sv
// Types shared by the backplane slave and its helpers
package vme_slave_pkg;

	typedef enum logic [1:0] {
		mem_idle,
		mem_host,
		mem_dsp
	} mem_owner_t;

	typedef struct packed {
		logic [31:0] addr;
		logic [5:0]  am;
		logic        as_n;
		logic [1:0]  ds_n;
		logic        lword_n;
		logic        write_n;
		logic        iack_n;
	} bus_req_t;

	typedef struct packed {
		logic       req;
		logic       we;
		logic [9:0] addr;
		logic [7:0] wdata;
	} dsp_req_t;

endpackage : vme_slave_pkg

// File: edge_irq.sv
// Pulse stretcher for one external interrupt into the on-board processor
`timescale 1ns/1ns
`default_nettype none

module edge_irq #(
	parameter int PULSE_CYC = 4
) (
	input  wire logic clk,
	input  wire logic sys_rst,
	input  wire logic trigger,
	output var  logic irq
);

	logic [$clog2(PULSE_CYC+1)-1:0] count;

	// Fixed-width pulse so the processor sees every event
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			count <= '0;
		end else if (trigger) begin
			count <= ($clog2(PULSE_CYC+1))'(PULSE_CYC);
		end else if (count != '0) begin
			count <= count - 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			irq <= 1'b0;
		end else begin
			irq <= trigger || (count > 1);
		end
	end

endmodule : edge_irq

`default_nettype wire

// File: mem_arbiter.sv
// Dual-port memory arbiter with fixed priority for the bus master
`timescale 1ns/1ns
`default_nettype none

module mem_arbiter
	import vme_slave_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       sys_rst,
	input  wire logic       host_req,
	input  wire logic       dsp_req,
	output var  mem_owner_t owner
);

	// Bus master wins any tie; the processor waits one cycle
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			owner <= mem_idle;
		end else if (host_req) begin
			owner <= mem_host;
		end else if (dsp_req) begin
			owner <= mem_dsp;
		end else begin
			owner <= mem_idle;
		end
	end

	host_first_a: assert property (@(posedge clk) disable iff (sys_rst)
		host_req |=> owner == mem_host) else $error("bus master not granted");

endmodule : mem_arbiter

`default_nettype wire

// File: vme_master_model.sv
// Behavioural backplane master that drives the slave under test
`timescale 1ns/1ns
`default_nettype none

module vme_master_model
	import vme_slave_pkg::*;
(
	input  wire logic        clk,
	input  wire logic [31:0] data_out,
	input  wire logic        dtack_n,
	output var  bus_req_t    bus,
	output var  logic [31:0] data_in,
	output var  logic [2:0]  iack_level
);

	// ------------------------------------------------------------------------
	// Idle bus
	// ------------------------------------------------------------------------
	initial begin
		bus = '{addr: 32'h0, am: 6'h00, as_n: 1'b1, ds_n: 2'h3,
			lword_n: 1'b1, write_n: 1'b1, iack_n: 1'b1};
		data_in = 32'h0;
		iack_level = 3'h0;
	end

	// ------------------------------------------------------------------------
	// One strobe cycle; width is {lword_n, ds_n}, ilev above 0 makes it an iack
	// ------------------------------------------------------------------------
	task automatic xfer(
		input  logic [5:0]  am,
		input  logic [31:0] addr,
		input  logic        wr,
		input  logic [31:0] wd,
		input  logic [2:0]  width,
		input  logic [2:0]  ilev,
		output logic [31:0] rd,
		output logic        ack
	);
		ack = 1'b0;
		rd = 32'h0;
		@(negedge clk);
		bus.am = am;
		bus.addr = {addr[31:2], 2'b00};
		bus.write_n = ~wr;
		bus.lword_n = width[2];
		bus.ds_n = width[1:0];
		bus.iack_n = (ilev == 3'h0);
		bus.as_n = 1'b0;
		iack_level = ilev;
		data_in = wd;
		// A refused cycle gives up after eight edges, as a bus timer would
		for (int i = 0; i < 8; i++) begin
			@(posedge clk);
			if (dtack_n === 1'b0) begin
				ack = 1'b1;
				rd = data_out;
				break;
			end
		end
		@(negedge clk);
		bus.as_n = 1'b1;
		bus.ds_n = 2'h3;
		bus.iack_n = 1'b1;
		// Released lines must not keep their last value
		bus.addr = ~bus.addr;
		data_in = ~data_in;
		repeat (2) @(negedge clk);
	endtask : xfer

endmodule : vme_master_model
`default_nettype wire

// File: tb_vme_slave_interrupt_interface.sv
// Self-checking bench for the backplane slave and its interrupt paths
`timescale 1ns/1ns
`default_nettype none
`include "vme_slave_map.svh"

module tb_vme_slave_interrupt_interface
	import vme_slave_pkg::*;
;
	localparam logic [7:0] board_base = 8'h42;

	logic        clk;
	logic        sys_rst;
	bus_req_t    bus;
	logic [2:0]  iack_level;
	logic [31:0] data_in;
	logic [31:0] data_out;
	logic        data_oe;
	logic        dtack_n;
	logic        dtack_oe;
	logic [7:1]  irq_n;
	dsp_req_t    dsp;
	logic [7:0]  dsp_rdata;
	logic        dsp_ready;
	logic        frame_start_marker;
	logic        diag_done;
	logic [3:0]  dsp_irq;
	logic [31:0] hi_cnt [4];
	logic [31:0] oe_cnt;
	logic [31:0] rd;
	logic        ack;
	logic [7:0]  b;
	int          fails;
	int          checked;
	int          cyc;

	// ------------------------------------------------------------------------
	// Instances
	// ------------------------------------------------------------------------
	vme_slave #(.DPR_DEPTH(1024)) dut_u (
		.clk(clk), .sys_rst(sys_rst), .bus(bus), .iack_level(iack_level),
		.data_in(data_in), .data_out(data_out), .data_oe(data_oe),
		.dtack_n(dtack_n), .dtack_oe(dtack_oe), .irq_n(irq_n),
		.base_switch(board_base), .dsp(dsp), .dsp_rdata(dsp_rdata),
		.dsp_ready(dsp_ready), .frame_start_marker(frame_start_marker),
		.diag_done(diag_done), .dsp_irq(dsp_irq)
	);

	vme_master_model mst_u (
		.clk(clk), .data_out(data_out), .dtack_n(dtack_n), .bus(bus),
		.data_in(data_in), .iack_level(iack_level)
	);

	// ------------------------------------------------------------------------
	// Clock, pulse counters and hang guard
	// ------------------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// Counting high cycles catches both a missing pulse and a wrong length
	always @(posedge clk) begin
		for (int i = 0; i < 4; i++) begin
			if (sys_rst) hi_cnt[i] <= 32'h0;
			else if (dsp_irq[i] === 1'b1) hi_cnt[i] <= hi_cnt[i] + 32'h1;
		end
		// Cycles in which the slave drives DTACK or the data lines
		if (sys_rst) oe_cnt <= 32'h0;
		else if (dtack_oe === 1'b1 || data_oe === 1'b1) oe_cnt <= oe_cnt + 32'h1;
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fails = fails + 1;
			close_out();
		end
	end

	// ------------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------------
	function automatic logic [31:0] at(input logic [23:0] off);
		return {board_base, off};
	endfunction : at

	function automatic logic [31:0] dpr(input logic [9:0] idx);
		return {board_base, `DPR_BASE_HI, 4'h0, idx, 2'b00};
	endfunction : dpr

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked = checked + 1;
		if (got !== exp) begin
			fails = fails + 1;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic idle(input int n);
		repeat (n) @(negedge clk);
	endtask : idle

	task automatic dsp_acc(input logic we, input logic [9:0] a, input logic [7:0] wd,
		output logic [7:0] rdat);
		@(negedge clk);
		dsp = '{req: 1'b1, we: we, addr: a, wdata: wd};
		rdat = 8'h00;
		for (int i = 0; i < 8; i++) begin
			@(posedge clk);
			if (dsp_ready === 1'b1) begin
				rdat = dsp_rdata;
				break;
			end
		end
		@(negedge clk);
		dsp.req = 1'b0;
		dsp.addr = ~dsp.addr;
		dsp.wdata = ~dsp.wdata;
	endtask : dsp_acc

	task automatic close_out;
		if (fails == 0 && checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : close_out

	// ------------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------------
	task automatic t_modifier;
		logic ok;
		for (int m = 0; m < 64; m++) begin
			ok = m[5:0] inside {6'h09, 6'h0a, 6'h0b, 6'h0d, 6'h0e, 6'h0f};
			mst_u.xfer(m[5:0], at(`CTL_IRQ_LEVEL), 1'b0, 32'h0, 3'b000, 3'h0, rd, ack);
			chk("modifier ack", {31'h0, ok}, {31'h0, ack});
		end
	endtask : t_modifier

	task automatic t_width;
		logic [31:0] s;
		mst_u.xfer(6'h09, at(`CTL_IRQ_LEVEL), 1'b1, 32'h1, 3'b000, 3'h0, rd, ack);
		s = oe_cnt;
		mst_u.xfer(6'h09, at(`CTL_IRQ_LEVEL), 1'b1, 32'h5, 3'b100, 3'h0, rd, ack);
		chk("word ack", 32'h0, {31'h0, ack});
		mst_u.xfer(6'h09, at(`CTL_IRQ_LEVEL), 1'b1, 32'h6, 3'b110, 3'h0, rd, ack);
		chk("byte ack", 32'h0, {31'h0, ack});
		mst_u.xfer(6'h09, at(`CTL_IRQ_LEVEL) ^ 32'h0100_0000, 1'b1, 32'h7, 3'b000, 3'h0, rd, ack);
		chk("other base ack", 32'h0, {31'h0, ack});
		chk("refused lines", s, oe_cnt);
		s = oe_cnt;
		mst_u.xfer(6'h0e, at(`CTL_IRQ_LEVEL), 1'b0, 32'h0, 3'b000, 3'h0, rd, ack);
		chk("level kept", 32'h1, {29'h0, rd[2:0]});
		chk("read drive cycles", s + 32'h3, oe_cnt);
	endtask : t_width

	task automatic t_dpr;
		mst_u.xfer(6'h0d, dpr(10'h005), 1'b1, 32'h1234_565a, 3'b000, 3'h0, rd, ack);
		mst_u.xfer(6'h0d, dpr(10'h005), 1'b0, 32'h0, 3'b000, 3'h0, rd, ack);
		chk("dpr readback", 32'h5a, rd);
		dsp_acc(1'b0, 10'h005, 8'h00, b);
		chk("proc read", 32'h5a, {24'h0, b});
		dsp_acc(1'b1, 10'h006, 8'hc3, b);
		mst_u.xfer(6'h0b, dpr(10'h006), 1'b0, 32'h0, 3'b000, 3'h0, rd, ack);
		chk("block read", 32'hc3, rd);
	endtask : t_dpr

	task automatic t_proc_irq;
		logic [31:0] s0;
		logic [31:0] s1;
		logic [31:0] s3;
		s0 = hi_cnt[0];
		s1 = hi_cnt[1];
		s3 = hi_cnt[3];
		mst_u.xfer(6'h09, dpr(`DPR_HOST_MBOX), 1'b1, 32'h11, 3'b000, 3'h0, rd, ack);
		idle(8);
		chk("mailbox pulse", s0 + `DSP_PULSE_CYC, hi_cnt[0]);
		frame_start_marker = 1'b1;
		idle(8);
		chk("frame rise pulse", s1 + `DSP_PULSE_CYC, hi_cnt[1]);
		frame_start_marker = 1'b0;
		idle(8);
		chk("frame fall pulse", s1 + 2 * `DSP_PULSE_CYC, hi_cnt[1]);
		diag_done = 1'b1;
		idle(8);
		chk("diag pulse", s3 + `DSP_PULSE_CYC, hi_cnt[3]);
		chk("spare line", 32'h0, hi_cnt[2]);
		diag_done = 1'b0;
	endtask : t_proc_irq

	task automatic t_bus_irq;
		mst_u.xfer(6'h0a, at(`CTL_IRQ_LEVEL), 1'b1, 32'h3, 3'b000, 3'h0, rd, ack);
		mst_u.xfer(6'h0a, at(`CTL_IRQ_VECTOR), 1'b1, 32'ha5, 3'b000, 3'h0, rd, ack);
		mst_u.xfer(6'h0a, at(`CTL_IRQ_VECTOR), 1'b0, 32'h0, 3'b000, 3'h0, rd, ack);
		chk("vector readback", 32'ha5, {24'h0, rd[7:0]});
		chk("no request yet", 32'h7f, {25'h0, irq_n});
		dsp_acc(1'b0, `DPR_DSP_MBOX, 8'h00, b);
		idle(4);
		chk("request level 3", 32'h7b, {25'h0, irq_n});
		mst_u.xfer(6'h0d, at(24'h0), 1'b0, 32'h0, 3'b000, 3'h2, rd, ack);
		chk("other level iack", 32'h0, {31'h0, ack});
		chk("request held", 32'h7b, {25'h0, irq_n});
		mst_u.xfer(6'h09, at(`CTL_IRQ_STATUS), 1'b0, 32'h0, 3'b000, 3'h0, rd, ack);
		chk("status pending", 32'h1, rd);
		mst_u.xfer(6'h0d, at(24'h0), 1'b0, 32'h0, 3'b000, 3'h3, rd, ack);
		chk("iack ack", 32'h1, {31'h0, ack});
		chk("iack vector", 32'ha5, {24'h0, rd[7:0]});
		chk("request cleared", 32'h7f, {25'h0, irq_n});
	endtask : t_bus_irq

	// ------------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------------
	initial begin
		fails = 0;
		checked = 0;
		cyc = 0;
		sys_rst = 1'b1;
		dsp = '{req: 1'b0, we: 1'b0, addr: 10'h000, wdata: 8'h00};
		frame_start_marker = 1'b0;
		diag_done = 1'b0;
		repeat (16) @(posedge clk);
		@(negedge clk);
		sys_rst = 1'b0;
		chk("reset irq_n", 32'h7f, {25'h0, irq_n});
		chk("reset dtack", 32'h1, {31'h0, dtack_n});
		t_modifier();
		t_width();
		t_dpr();
		t_proc_irq();
		t_bus_irq();
		close_out();
	end

endmodule : tb_vme_slave_interrupt_interface
`default_nettype wire
